// [charger_done_params.svh]
// constants for the charger done-state control block
`ifndef CHARGER_DONE_PARAMS_SVH
`define CHARGER_DONE_PARAMS_SVH
`define TMR_CFG_ADDR 8'h8A
`define TMR_CFG_RESET 8'h0A
`define TMR_CFG_WMASK 8'hBF
`define PRE_BIT 7
`define EOC_LSB 3
`define FCT_LSB 0
`define STATE_CODE_EOC 8'h03
`define STATE_CODE_DONE 8'h04
`define STATE_CODE_CC 8'h02
`define STATE_CODE_WDOG 8'h05
`define CLK_HZ 100000000
`define EOC_STEP_MIN 10
`define FCT_STEP_HOUR 2
`define EOC_DEBOUNCE_S 16
`define SEC_CYCLES_DEF 100000000
`define DB_CYCLES_DEF 1600000000
`define CHG_DEFAULT_MA 10'd100
`define CHG_ZERO_MA 10'd0
`define STATE_CODE_OFF 8'h00
`define SEC_PER_MIN 60
`define SEC_PER_HOUR 3600
`endif

// [charger_done_pkg.sv]
// types for the charger done-state control block
package charger_done_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_CC = 3'b001,
        ST_EOC = 3'b010,
        ST_DONE = 3'b011,
        ST_WDOG = 3'b100,
        ST_SUPPL = 3'b101
    } chg_state_e;
    typedef struct packed {
        logic sys_below_batt;
        logic batt_below_restart;
        logic input_over_limit;
        logic input_volt_low;
        logic supply_present;
        logic batt_low;
    } cmp_s;
    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage : charger_done_pkg

// [charger_done_state_control.sv]
// charger end-of-charge, done, supplement and input limit control
//
// Contract
// - eoc code 0 debounce 16 s, else 10-70 min
// - timer config register 0x8A, reset 0x0A
// - eoc lasts selected time then done
// - done debounced: irq, clear ok, code 04
// - done exits to cc below restart
// - done exits to watchdog suspend on expiry
// - done: zero current, isolation switch closed
// - done to cc: current steps immediately
// - rail below battery: suspend, supplement mode
// - rail above battery: resume in cc
// - low battery: regulate rail to selection
// - supply appears: enable regulator, 100 mA; the code charges at cc_current_ma instead
// - over input limit: reduce charge current
// - sense amp on only with supply good
// - input voltage low: irq, reduce current
// - fast timer code 0 off, else 2-14 h
// - eoc debounced: irq, set ok, code 03
`timescale 1ns/1ps
`include "charger_done_params.svh"
module charger_done_state_control #(
    parameter logic [31:0] SEC_CYCLES = `SEC_CYCLES_DEF,
    parameter logic [31:0] DB_CYCLES = `DB_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire charger_done_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // analog comparators, raw, then supply good, requests and settings
    input wire charger_done_pkg::cmp_s cmp_raw,
    input wire logic internal_supply_good,
    input wire logic eoc_entry_req,
    input wire logic watchdog_expired,
    input wire logic otp_charge_on,
    input wire logic [1:0] rail_target_sel,
    input wire logic [9:0] cc_current_ma,
    // control outputs
    output logic charger_irq,
    output logic charge_ok_flag,
    output logic [7:0] charger_state_code,
    output logic [9:0] charge_current_ma,
    output logic battery_isolation_switch,
    output logic supplement_mode,
    output logic linear_reg_en,
    output logic sense_amp_en,
    output logic [1:0] rail_target,
    output logic rail_reg_en,
    output logic current_reduce,
    output logic fast_timer_fault
);
    import charger_done_pkg::*;

    // ****************************************
    // register and synchronisers
    // ****************************************
    logic [7:0] timer_cfg_r;
    cmp_s sync1_r;
    cmp_s sync2_r;
    logic vlow_prev_r;
    wire sel_cfg = (reg_req.addr == `TMR_CFG_ADDR);
    wire [2:0] eoc_timer_sel = timer_cfg_r[`EOC_LSB +: 3];
    wire [2:0] fast_charge_timer_sel = timer_cfg_r[`FCT_LSB +: 3];
    wire precharge_timer_sel = timer_cfg_r[`PRE_BIT];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_cfg_r <= `TMR_CFG_RESET;
        end else if (reg_req.we && sel_cfg) begin
            timer_cfg_r <= reg_req.wdata & `TMR_CFG_WMASK;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            vlow_prev_r <= 1'b0;
        end else begin
            sync1_r <= cmp_raw;
            sync2_r <= sync1_r;
            // edge history from the settled stage only
            vlow_prev_r <= sync2_r.input_volt_low;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.re) begin
            reg_rdata <= sel_cfg ? timer_cfg_r : 8'h00;
        end
    end

    // ****************************************
    // timebase
    // ****************************************
    // one second tick clocks the eoc and fast timer counters, which count seconds
    logic [31:0] presc_r;
    logic [31:0] sec_r;
    logic [31:0] db_r;
    logic [31:0] fct_r;
    wire tick = (presc_r == SEC_CYCLES - 32'h1);

    // eoc duration in seconds; code 0 is the debounce only
    function automatic logic [31:0] eoc_secs(input logic [2:0] code);
        if (code == 3'h0) begin
            eoc_secs = 32'(`EOC_DEBOUNCE_S);
        end else begin
            eoc_secs = 32'(code) * 32'(`EOC_STEP_MIN) *
                32'(`SEC_PER_MIN);
        end
    endfunction : eoc_secs

    function automatic logic [31:0] fct_secs(input logic [2:0] code);
        fct_secs = 32'(code) * 32'(`FCT_STEP_HOUR) *
            32'(`SEC_PER_HOUR);
    endfunction : fct_secs

    // status code reported for a state
    function automatic logic [7:0] status_code(input chg_state_e s);
        case (s)
            ST_CC: begin
                status_code = `STATE_CODE_CC;
            end
            ST_EOC: begin
                status_code = `STATE_CODE_EOC;
            end
            ST_DONE: begin
                status_code = `STATE_CODE_DONE;
            end
            ST_WDOG: begin
                status_code = `STATE_CODE_WDOG;
            end
            default: begin
                status_code = `STATE_CODE_OFF;
            end
        endcase
    endfunction : status_code

    // ****************************************
    // state machine
    // ****************************************
    chg_state_e state_r;
    chg_state_e state_nxt;
    logic flag_done_r;

    wire supply_on = sync2_r.supply_present;
    wire eoc_elapsed = (sec_r >= eoc_secs(eoc_timer_sel));
    wire db_elapsed = (db_r >= DB_CYCLES - 32'h1);
    wire fct_on = (fast_charge_timer_sel != 3'h0);
    wire fct_expired = fct_on && (fct_r >= fct_secs(fast_charge_timer_sel));
    wire charging = (state_r == ST_CC) || (state_r == ST_EOC);
    wire state_change = (state_nxt != state_r);
    // prescaler restarts on entry, so state timers land on the tick
    wire presc_clr = tick || state_change;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (supply_on && otp_charge_on) begin
                    state_nxt = ST_CC;
                end
            end
            ST_CC: begin
                if (eoc_entry_req) begin
                    state_nxt = ST_EOC;
                end
            end
            ST_EOC: begin
                if (watchdog_expired) begin
                    state_nxt = ST_WDOG;
                end else if (sync2_r.batt_below_restart) begin
                    state_nxt = ST_CC;
                end else if (eoc_elapsed) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                if (watchdog_expired) begin
                    state_nxt = ST_WDOG;
                end else if (sync2_r.batt_below_restart) begin
                    state_nxt = ST_CC;
                end
            end
            ST_SUPPL: begin
                if (!sync2_r.sys_below_batt) begin
                    state_nxt = ST_CC;
                end
            end
            ST_WDOG: begin
                state_nxt = ST_WDOG;
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        if (charging && sync2_r.sys_below_batt) begin
            state_nxt = ST_SUPPL;
        end
        if (!supply_on) begin
            state_nxt = ST_OFF;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_OFF;
            presc_r <= 32'h0;
            sec_r <= 32'h0;
            db_r <= 32'h0;
            fct_r <= 32'h0;
            flag_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            presc_r <= presc_clr ? 32'h0 : presc_r + 32'h1;
            if (state_change) begin
                sec_r <= 32'h0;
                db_r <= 32'h0;
                flag_done_r <= 1'b0;
            end else begin
                if (tick) begin
                    sec_r <= sec_r + 32'h1;
                end
                if (!db_elapsed) begin
                    db_r <= db_r + 32'h1;
                end else begin
                    flag_done_r <= 1'b1;
                end
            end
            if (state_r != ST_CC) begin
                fct_r <= 32'h0;
            end else if (tick) begin
                fct_r <= fct_r + 32'h1;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    wire db_event = db_elapsed && !flag_done_r;
    wire eoc_event = db_event && (state_r == ST_EOC);
    wire done_event = db_event && (state_r == ST_DONE) &&
        (state_nxt == ST_DONE);
    // one pulse per drop, not a level, so irq stays a strobe
    wire vlow_event = sync2_r.input_volt_low && !vlow_prev_r &&
        charging;
    // these states report on entry, in step with the drive outputs
    wire code_follows = (state_nxt == ST_CC) || (state_nxt == ST_WDOG) ||
        (state_nxt == ST_OFF);
    wire reduce = sync2_r.input_over_limit || sync2_r.input_volt_low;
    // cc target is taken whole, no ramp toward it
    wire [9:0] cc_target = supply_on ? cc_current_ma : `CHG_ZERO_MA;
    wire [9:0] reduced = {1'b0, cc_target[9:1]};
    wire [9:0] cur_nxt = (state_nxt == ST_DONE) ? `CHG_ZERO_MA :
        (state_nxt == ST_SUPPL || state_nxt == ST_OFF) ? `CHG_ZERO_MA :
        (state_nxt == ST_EOC || state_nxt == ST_CC) ?
        (reduce ? reduced : cc_target) : `CHG_ZERO_MA;

    // status: irq strobe, charge-ok and state code
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            charger_irq <= 1'b0;
            charge_ok_flag <= 1'b0;
            charger_state_code <= `STATE_CODE_OFF;
        end else begin
            charger_irq <= eoc_event || done_event || vlow_event;
            if (eoc_event) begin
                charge_ok_flag <= 1'b1;
                charger_state_code <= status_code(ST_EOC);
            end else if (done_event) begin
                charge_ok_flag <= 1'b0;
                charger_state_code <= status_code(ST_DONE);
            end else if (code_follows) begin
                charger_state_code <= status_code(state_nxt);
            end
        end
    end

    // drive outputs; current, isolation and supplement from the next state so they move together
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            charge_current_ma <= `CHG_ZERO_MA;
            battery_isolation_switch <= 1'b0;
            supplement_mode <= 1'b0;
            linear_reg_en <= 1'b0;
            sense_amp_en <= 1'b0;
            rail_target <= 2'b00;
            rail_reg_en <= 1'b0;
            current_reduce <= 1'b0;
            fast_timer_fault <= 1'b0;
        end else begin
            charge_current_ma <= cur_nxt;
            battery_isolation_switch <= (state_nxt == ST_DONE) ||
                (state_nxt == ST_SUPPL);
            supplement_mode <= (state_nxt == ST_SUPPL);
            linear_reg_en <= supply_on;
            sense_amp_en <= internal_supply_good && supply_on;
            rail_target <= rail_target_sel;
            rail_reg_en <= supply_on && sync2_r.batt_low;
            current_reduce <= reduce && charging;
            fast_timer_fault <= fct_expired && !precharge_timer_sel ?
                1'b1 : fct_expired;
        end
    end
endmodule : charger_done_state_control

// [charger_done_state_control_chk.sv]
// assertion checker for the charger done-state control block
`timescale 1ns/1ps
module charger_done_state_control_chk (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watched ports
    input wire charger_done_pkg::reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic internal_supply_good,
    input wire logic charger_irq,
    input wire logic charge_ok_flag,
    input wire logic [7:0] charger_state_code,
    input wire logic [9:0] charge_current_ma,
    input wire logic battery_isolation_switch,
    input wire logic supplement_mode,
    input wire logic sense_amp_en
);
    import charger_done_pkg::*;
    wire logic in_eoc = charger_state_code == 8'h03;
    wire logic in_done = charger_state_code == 8'h04;
    wire logic no_cur = charge_current_ma == 10'h000;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_irq_one_pulse: assert property (charger_irq |=> !charger_irq)
        else $error("irq too long");
    a_ok_at_eoc: assert property ($rose(charge_ok_flag) |-> in_eoc)
        else $error("ok set outside eoc");
    a_done_entry: assert property ($rose(in_done)
        |-> charger_irq && !charge_ok_flag) else $error("done entry");
    a_done_idle: assert property (in_done
        |-> no_cur && battery_isolation_switch) else $error("done output");
    a_sense_off: assert property (!internal_supply_good [*4]
        |=> !sense_amp_en) else $error("sense amp on");
    a_unmapped_zero: assert property (reg_req.re
        && reg_req.addr != 8'h8A |=> reg_rdata == 8'h00) else $error("map");
    a_reserved_zero: assert property (reg_req.re |=> !reg_rdata[6])
        else $error("reserved bit set");
    a_supp_no_charge: assert property (supplement_mode |-> no_cur)
        else $error("charging in supplement");
    c_done: cover property ($rose(in_done));
    c_supp: cover property ($rose(supplement_mode));
    c_irq: cover property (charger_irq);
endmodule : charger_done_state_control_chk
bind charger_done_state_control charger_done_state_control_chk chk_u (
    .clk, .sys_rst, .reg_req, .reg_rdata, .internal_supply_good,
    .charger_irq, .charge_ok_flag, .charger_state_code, .charge_current_ma,
    .battery_isolation_switch, .supplement_mode, .sense_amp_en);

// [charger_done_state_control_tb.sv]
// self-checking bench for the charger done-state control block
`timescale 1ns/1ps
module charger_done_state_control_tb;
    import charger_done_pkg::*;
    // short counts keep eoc timing inside the run
    localparam logic [31:0] SEC = 32'hA;
    logic clk = 1'b0, sys_rst = 1'b1, internal_supply_good = 1'b0;
    logic eoc_entry_req = 1'b0, watchdog_expired = 1'b0, otp_charge_on = 1'b1;
    logic [1:0] rail_target_sel = 2'h2, rail_target;
    logic [9:0] cc_current_ma = 10'h064, charge_current_ma;
    logic [7:0] reg_rdata, charger_state_code, rv, cfg;
    logic charger_irq, charge_ok_flag, battery_isolation_switch, rail_reg_en;
    logic supplement_mode, linear_reg_en, sense_amp_en, current_reduce;
    logic fast_timer_fault;
    logic [9:0] obs [5];
    reg_req_s reg_req;
    cmp_s cmp_raw = '0;
    int mismatches = 0, compares = 0, e, d;
    time t0;
    charger_done_state_control #(.SEC_CYCLES(SEC), .DB_CYCLES(32'h5)) dut_u (
        .clk, .sys_rst, .reg_req, .reg_rdata, .cmp_raw, .internal_supply_good,
        .eoc_entry_req, .watchdog_expired, .otp_charge_on, .rail_target_sel,
        .cc_current_ma, .charger_irq, .charge_ok_flag, .charger_state_code,
        .charge_current_ma, .battery_isolation_switch, .supplement_mode,
        .linear_reg_en, .sense_amp_en, .rail_target, .rail_reg_en,
        .current_reduce, .fast_timer_fault);
    charger_host_model host_u (.clk, .reg_req, .reg_rdata);
    assign obs = '{10'(charger_state_code), 10'(supplement_mode),
        10'(current_reduce), 10'(charger_irq), 10'({rail_reg_en, rail_target})};
    initial forever #5 clk = ~clk;
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int k, input logic [9:0] v);
        int i;
        for (i = 0; i < 20000 && obs[k] !== v; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 20000) begin
            mismatches++;
            $display("BAD %0t wait %0d timed out", $time, k);
            tally_and_finish();
        end
    endtask : wt
    initial begin
        void'($urandom(32'h0F63509E));
        cfg = 8'($urandom);
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        host_u.rd(8'h8A, rv);
        chk(rv, 8'h0A);
        host_u.wr(8'h8A, cfg);
        host_u.rd(8'h8A, rv);
        chk(rv, cfg & 8'hBF);
        host_u.rd(8'h8B + 8'($urandom_range(0, 254)), rv);
        chk(rv, 8'h00);
        cmp_raw.supply_present <= 1'b1;
        internal_supply_good <= 1'b1;
        wt(0, 8'h02);
        chk(linear_reg_en, 1'b1);
        chk(sense_amp_en, 1'b1);
        chk(charge_current_ma, 10'h064);
        @(posedge clk);
        internal_supply_good <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(sense_amp_en, 1'b0);
        @(posedge clk);
        internal_supply_good <= 1'b1;
        @(posedge clk);
        cmp_raw.sys_below_batt <= 1'b1;
        wt(1, 1'b1);
        chk(charge_current_ma, 10'h000);
        @(posedge clk);
        cmp_raw.sys_below_batt <= 1'b0;
        wt(1, 1'b0);
        chk(charger_state_code, 8'h02);
        chk(charge_current_ma, cc_current_ma);
        @(posedge clk);
        cmp_raw.input_over_limit <= 1'b1;
        cmp_raw.batt_low <= 1'b1;
        wt(2, 1'b1);
        chk(charge_current_ma, 10'h032);
        wt(4, 10'h006);
        @(posedge clk);
        cmp_raw.input_over_limit <= 1'b0;
        cmp_raw.input_volt_low <= 1'b1;
        wt(3, 1'b1);
        @(posedge clk);
        cmp_raw.input_volt_low <= 1'b0;
        wt(2, 1'b0);
        // last pass leaves done through the watchdog instead
        for (int n = 0; n < 3; n++) begin
            host_u.wr(8'h8A, {2'h0, 3'(n), 3'h2});
            cc_current_ma <= 10'($urandom_range(100, 1000));
            eoc_entry_req <= 1'b1;
            wt(0, 8'h03);
            chk(charge_ok_flag, 1'b1);
            t0 = $time;
            wt(0, 8'h04);
            e = (n == 0) ? 16 * SEC : n * 600 * SEC;
            d = int'(($time - t0) / 10);
            chk(d > e - 4 && d < e + 4, 1'b1);
            chk(charge_ok_flag, 1'b0);
            chk(charge_current_ma, 10'h000);
            chk(battery_isolation_switch, 1'b1);
            @(posedge clk);
            eoc_entry_req <= 1'b0;
            cmp_raw.batt_below_restart <= n < 2;
            watchdog_expired <= n == 2;
            wt(0, (n < 2) ? 8'h02 : 8'h05);
            if (n < 2) chk(charge_current_ma, cc_current_ma);
            @(posedge clk);
            cmp_raw.batt_below_restart <= 1'b0;
        end
        #1;
        chk(fast_timer_fault, 1'b0);
        tally_and_finish();
    end
endmodule : charger_done_state_control_tb

// [charger_host_model.sv]
// host model on the register port of the charger block
`timescale 1ns/1ps
module charger_host_model (
    // clock
    input wire logic clk,
    // register port
    output charger_done_pkg::reg_req_s reg_req,
    input wire logic [7:0] reg_rdata
);
    import charger_done_pkg::*;
    initial reg_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : charger_host_model
